// ==== fgp_consts.vh ====
`ifndef FGP_CONSTS_VH
`define FGP_CONSTS_VH

// register index is byte address bits [5:2], port select is bit 6
`define FGP_IDX_DIR 4'h0
`define FGP_IDX_MASK 4'h1
`define FGP_IDX_PIN 4'h2
`define FGP_IDX_OUT 4'h3
`define FGP_IDX_SET 4'h4
`define FGP_IDX_CLR 4'h5
`define FGP_IDX_RISE 4'h6
`define FGP_IDX_FALL 4'h7
`define FGP_IDX_STAT 4'h8
`define FGP_IDX_IMASK 4'h9
`define FGP_IDX_LAST 4'h9

`define FGP_IDX_MSB 5
`define FGP_IDX_LSB 2
`define FGP_ADDR_W 8
`define FGP_PORT_BIT 6
`define FGP_TOP_BIT 7
`define FGP_NPORT 2
`define FGP_W 32

`define FGP_RST_WORD 32'h0000_0000
`define FGP_RESP_OKAY 2'b00
`define FGP_RESP_SLVERR 2'b10

`endif

// ==== fgp_edge_cell.v ====
`default_nettype none

module fgp_edge_cell (
    input wire clk,
    input wire sys_rst,
    input wire pin,
    input wire riseEn,
    input wire fallEn,
    output wire evt,
    output wire armed
);
    reg riseCap;
    reg fallCap;
    reg syncA_q;
    reg syncB_q;
    reg ack_q;
    wire clrCap;

    // caps are cleared only after the bus side has seen them; an edge in that window is lost
    assign clrCap = sys_rst | ack_q;

    // clocked by the pin itself so edges are caught with the system clock stopped
    always @(posedge pin or posedge clrCap) begin
        if (clrCap) begin
            riseCap <= 1'b0;
        end else begin
            riseCap <= riseEn;
        end
    end

    always @(negedge pin or posedge clrCap) begin
        if (clrCap) begin
            fallCap <= 1'b0;
        end else begin
            fallCap <= fallEn;
        end
    end

    assign armed = riseCap | fallCap;

    always @(posedge clk) begin
        if (sys_rst) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            syncA_q <= armed;
            syncB_q <= syncA_q;
            ack_q <= syncB_q;
        end
    end

    assign evt = syncB_q & ~ack_q;
endmodule

`default_nettype wire

// ==== fgp_axil_slave.v ====
`include "fgp_consts.vh"
`default_nettype none

module fgp_axil_slave (
    input wire clk,
    input wire sys_rst,
    input wire [`FGP_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`FGP_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire wrPulse,
    output reg [`FGP_ADDR_W-1:0] wrAddr,
    output reg [31:0] wrData,
    output reg [3:0] wrStrb,
    input wire wrOk,
    output wire rdPulse,
    output reg [`FGP_ADDR_W-1:0] rdAddr,
    input wire [31:0] rdData,
    input wire rdOk
);
    reg awHeld_q;
    reg wHeld_q;
    reg rdPend_q;

    assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;
    assign s_axi_arready = ~rdPend_q & ~s_axi_rvalid;
    assign wrPulse = awHeld_q & wHeld_q;
    assign rdPulse = rdPend_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            wrAddr <= {`FGP_ADDR_W{1'b0}};
            wrData <= `FGP_RST_WORD;
            wrStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FGP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                wrAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
            end
            if (wrPulse) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrOk ? `FGP_RESP_OKAY : `FGP_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            rdPend_q <= 1'b0;
            rdAddr <= {`FGP_ADDR_W{1'b0}};
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `FGP_RST_WORD;
            s_axi_rresp <= `FGP_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rdPend_q <= 1'b1;
                rdAddr <= s_axi_araddr;
            end
            if (rdPend_q) begin
                rdPend_q <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdOk ? rdData : `FGP_RST_WORD;
                s_axi_rresp <= rdOk ? `FGP_RESP_OKAY : `FGP_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ==== fgp_gpio_top.v ====
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`include "fgp_consts.vh"
`default_nettype none

// Contract
// - Port registers drive and sense only pins not handed to a dedicated peripheral.
// - Each pin has its own direction bit, changeable by software at any time.
// - After reset every pin is an input with its driver off.
// - Set and clear locations drive chosen output bits high or low, zeros leave bits alone.
// - Software can read the output latch and, separately, the sensed pin levels.
// - A per-bit mask hides pins from port reads and writes, including set and clear.
// - Byte, halfword and word accesses all work, touching only the addressed lanes.
// - One full-width write updates a whole port output value at once.
// - The port registers are a slave on the fast system bus.
// - Each pin on the interrupt ports can flag a rising edge, a falling edge, or both.
// - Edge detection works asynchronously, without any running clock.
// - Each enabled pin edge can wake the chip from power-down.
module fgp_gpio_top (
    input wire clk,
    input wire sys_rst,
    input wire [`FGP_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`FGP_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [`FGP_NPORT*`FGP_W-1:0] pinIn,
    input wire [`FGP_NPORT*`FGP_W-1:0] pinSel,
    output wire [`FGP_NPORT*`FGP_W-1:0] pinOut,
    output wire [`FGP_NPORT*`FGP_W-1:0] pinOe,
    output wire irq,
    output wire wake
);
    wire wrPulse;
    wire [`FGP_ADDR_W-1:0] wrAddr;
    wire [31:0] wrData;
    wire [3:0] wrStrb;
    wire [`FGP_ADDR_W-1:0] rdAddr;
    wire [31:0] rdData;
    wire wrOk;
    wire rdOk;
    wire [31:0] laneMask;
    wire [3:0] wrIdx;
    wire [3:0] rdIdx;
    wire [`FGP_NPORT*`FGP_W-1:0] rdAll;
    wire [`FGP_NPORT-1:0] irqPort;
    wire [`FGP_NPORT-1:0] wakePort;

    fgp_axil_slave uBus (
        .clk(clk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrPulse(wrPulse),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdPulse(),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    // byte lanes of a narrow access are the only bits a write may touch
    assign laneMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};
    assign wrIdx = wrAddr[`FGP_IDX_MSB:`FGP_IDX_LSB];
    assign rdIdx = rdAddr[`FGP_IDX_MSB:`FGP_IDX_LSB];
    assign wrOk = ~wrAddr[`FGP_TOP_BIT] && (wrIdx <= `FGP_IDX_LAST);
    assign rdOk = ~rdAddr[`FGP_TOP_BIT] && (rdIdx <= `FGP_IDX_LAST);
    assign rdData = rdAddr[`FGP_PORT_BIT] ? rdAll[2*`FGP_W-1:`FGP_W] : rdAll[`FGP_W-1:0];

    genvar p;
    genvar b;
    generate
        for (p = 0; p < `FGP_NPORT; p = p + 1) begin : gPort
            reg [31:0] dir_q;
            reg [31:0] mask_q;
            reg [31:0] out_q;
            reg [31:0] riseEn_q;
            reg [31:0] fallEn_q;
            reg [31:0] stat_q;
            reg [31:0] imask_q;
            reg [31:0] pinS1_q;
            reg [31:0] pinS2_q;
            reg [31:0] rdVal;
            wire [31:0] sel;
            wire [31:0] evt;
            wire [31:0] armed;
            wire [31:0] wm;
            wire [31:0] sense;
            wire hit;

            assign sel = pinSel[p*`FGP_W +: `FGP_W];
            assign hit = wrPulse && wrOk && (wrAddr[`FGP_PORT_BIT] ? (p == 1) : (p == 0));
            // unmasked lanes of this access; masked bits are never written
            assign wm = laneMask & ~mask_q;
            // pins owned by a peripheral read as zero here
            assign sense = pinS2_q & ~sel;

            always @(posedge clk) begin
                if (sys_rst) begin
                    pinS1_q <= `FGP_RST_WORD;
                    pinS2_q <= `FGP_RST_WORD;
                end else begin
                    pinS1_q <= pinIn[p*`FGP_W +: `FGP_W];
                    pinS2_q <= pinS1_q;
                end
            end

            always @(posedge clk) begin
                if (sys_rst) begin
                    dir_q <= `FGP_RST_WORD;
                    mask_q <= `FGP_RST_WORD;
                    out_q <= `FGP_RST_WORD;
                    riseEn_q <= `FGP_RST_WORD;
                    fallEn_q <= `FGP_RST_WORD;
                    imask_q <= `FGP_RST_WORD;
                end else if (hit) begin
                    case (wrIdx)
                        `FGP_IDX_DIR: begin
                            dir_q <= (dir_q & ~laneMask) | (wrData & laneMask);
                        end
                        `FGP_IDX_MASK: begin
                            mask_q <= (mask_q & ~laneMask) | (wrData & laneMask);
                        end
                        `FGP_IDX_PIN, `FGP_IDX_OUT: begin
                            out_q <= (out_q & ~wm) | (wrData & wm);
                        end
                        `FGP_IDX_SET: begin
                            out_q <= out_q | (wrData & wm);
                        end
                        `FGP_IDX_CLR: begin
                            out_q <= out_q & ~(wrData & wm);
                        end
                        `FGP_IDX_RISE: begin
                            riseEn_q <= (riseEn_q & ~laneMask) | (wrData & laneMask);
                        end
                        `FGP_IDX_FALL: begin
                            fallEn_q <= (fallEn_q & ~laneMask) | (wrData & laneMask);
                        end
                        `FGP_IDX_IMASK: begin
                            imask_q <= (imask_q & ~laneMask) | (wrData & laneMask);
                        end
                        default: begin
                            out_q <= out_q;
                        end
                    endcase
                end
            end

            // a new event in the clearing cycle survives: set wins over clear
            always @(posedge clk) begin
                if (sys_rst) begin
                    stat_q <= `FGP_RST_WORD;
                end else if (hit && (wrIdx == `FGP_IDX_STAT)) begin
                    stat_q <= (stat_q & ~(wrData & laneMask)) | evt;
                end else begin
                    stat_q <= stat_q | evt;
                end
            end

            always @* begin
                case (rdIdx)
                    `FGP_IDX_DIR: rdVal = dir_q;
                    `FGP_IDX_MASK: rdVal = mask_q;
                    `FGP_IDX_PIN: rdVal = sense & ~mask_q;
                    `FGP_IDX_OUT: rdVal = out_q & ~mask_q;
                    `FGP_IDX_SET: rdVal = out_q & ~mask_q;
                    `FGP_IDX_CLR: rdVal = out_q & ~mask_q;
                    `FGP_IDX_RISE: rdVal = riseEn_q;
                    `FGP_IDX_FALL: rdVal = fallEn_q;
                    `FGP_IDX_STAT: rdVal = stat_q;
                    `FGP_IDX_IMASK: rdVal = imask_q;
                    default: rdVal = `FGP_RST_WORD;
                endcase
            end

            assign rdAll[p*`FGP_W +: `FGP_W] = rdVal;
            assign pinOut[p*`FGP_W +: `FGP_W] = out_q;
            assign pinOe[p*`FGP_W +: `FGP_W] = dir_q & ~sel;
            assign irqPort[p] = |(stat_q & imask_q);
            // wake is raw and clockless so it works while the bus clock is stopped
            assign wakePort[p] = |armed;

            for (b = 0; b < `FGP_W; b = b + 1) begin : gBit
                fgp_edge_cell uCell (
                    .clk(clk),
                    .sys_rst(sys_rst),
                    .pin(pinIn[p*`FGP_W + b]),
                    .riseEn(riseEn_q[b] & ~sel[b]),
                    .fallEn(fallEn_q[b] & ~sel[b]),
                    .evt(evt[b]),
                    .armed(armed[b])
                );
            end
        end
    endgenerate

    assign irq = |irqPort;
    assign wake = |wakePort;
endmodule

`default_nettype wire

// ==== fgp_gpio_chk.sv ====
`include "fgp_consts.vh"
`default_nettype none
module fgp_gpio_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [63:0] pinSel,
    input wire logic [63:0] pinOut,
    input wire logic [63:0] pinOe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] awQ;
    function automatic logic bad(input logic [7:0] a);
        return a[7] || a[5:2] > `FGP_IDX_LAST;
    endfunction
    // the response rises one edge after address and data are both taken, so this copy is current
    always_ff @(posedge clk) begin
        if (s_axi_awvalid && s_axi_awready) awQ <= s_axi_awaddr;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_BRESP: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
        (bad(awQ) ? `FGP_RESP_SLVERR : `FGP_RESP_OKAY)) else $error("bad write response");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
        !s_axi_rvalid ##1 s_axi_rvalid) else $error("read answer timing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    AST_OE_SEL: assert property ((pinOe & pinSel) == 64'h0)
        else $error("peripheral pin driven");
    AST_RST: assert property ($past(sys_rst) |-> pinOe == 64'h0 && pinOut == 64'h0 && !irq)
        else $error("reset state wrong");
    AST_OUT_WR: assert property ($changed(pinOut) && !$past(sys_rst) |->
        $rose(s_axi_bvalid)) else $error("latch moved without write");
    cover property (s_axi_bvalid && s_axi_bresp == `FGP_RESP_SLVERR);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// ==== fgp_pin_model.sv ====
`default_nettype none
module fgp_pin_model (
    input wire logic [63:0] pinOut,
    input wire logic [63:0] pinOe,
    input wire logic [63:0] extLvl,
    output wire logic [63:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // board settles a little after the clock edge, so pin edges land between clock edges
    assign #7 pinIn = (pinOe & pinOut) | (~pinOe & extLvl);
endmodule
`default_nettype wire

// ==== test_fast_gpio_port_edge_wake.sv ====
`include "fgp_consts.vh"
`default_nettype none
`define CHK(g, e) begin gotV = (g); expV = (e); nChecks++; if (gotV !== expV) begin \
    miscompares++; $display("unexpected t=%0t got %h exp %h", $time, gotV, expV); end end
module test_fast_gpio_port_edge_wake;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, seed, dirM, outM, mskM, v, lm;
    logic [3:0] s_axi_wstrb;
    logic lateRdy;
    logic [63:0] pinSel, extLvl, gotV, expV;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, wake;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [63:0] pinIn, pinOut, pinOe;
    int miscompares, nChecks, cyc;
    logic [3:0] sl [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc};
    logic [1:0] expB [$];
    logic [33:0] expR [$];
    fgp_gpio_top DUT (.*);
    fgp_pin_model partner (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic bad(input logic [7:0] a);
        return a[7] || a[5:2] > `FGP_IDX_LAST;
    endfunction
    function automatic logic [7:0] ad(input logic p, input logic [3:0] i);
        return {1'b0, p, i, 2'b00};
    endfunction
    // lateRdy raises bready/rready only once the answer is seen, so the hold checks get exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic done;
        expB.push_back(bad(a) ? `FGP_RESP_SLVERR : `FGP_RESP_OKAY);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !lateRdy;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid && s_axi_bready;
            if (s_axi_bvalid) s_axi_bready <= !s_axi_bready;
        end while (!done);
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic done;
        expR.push_back({bad(a) ? `FGP_RESP_SLVERR : `FGP_RESP_OKAY, bad(a) ? 32'h0 : e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !lateRdy;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid && s_axi_rready;
            if (s_axi_rvalid) s_axi_rready <= !s_axi_rready;
        end while (!done);
        @(posedge clk);
    endtask
    task automatic summarize();
        if (expB.size() + expR.size() != 0) miscompares++;
        $display("checks %0d miscompares %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (s_axi_bvalid && s_axi_bready)
            `CHK(s_axi_bresp, expB.pop_front())
        if (s_axi_rvalid && s_axi_rready)
            `CHK({s_axi_rresp, s_axi_rdata}, expR.pop_front())
        if (cyc == 3000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        seed = 32'hdaa1;
        lateRdy = 1'b0;
        sys_rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        pinSel = 64'h0;
        extLvl = 64'h0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK(pinOe, 64'h0)
        for (int i = 0; i < 24; i++) begin
            lateRdy = i[0];
            rd(ad(1'(i / 12), 4'(i % 12)), 32'h0);
        end
        lateRdy = 1'b0;
        rd(8'h80, 32'h1);
        dirM = rnd();
        outM = rnd();
        wr(ad(0, `FGP_IDX_DIR), dirM, 4'hf);
        wr(ad(0, `FGP_IDX_OUT), outM, 4'hf);
        `CHK(pinOe[31:0], dirM)
        `CHK(pinOut[31:0], outM)
        rd(ad(0, `FGP_IDX_OUT), outM);
        extLvl[31:0] <= rnd();
        repeat (3) @(posedge clk);
        rd(ad(0, `FGP_IDX_PIN), dirM & outM | ~dirM & extLvl[31:0]);
        v = rnd();
        pinSel[31:0] <= v;
        repeat (3) @(posedge clk);
        `CHK(pinOe[31:0], dirM & ~v)
        rd(ad(0, `FGP_IDX_PIN), (dirM & outM | ~dirM & extLvl[31:0]) & ~v);
        pinSel <= 64'h0;
        v = rnd();
        wr(ad(0, `FGP_IDX_SET), v, 4'hf);
        outM |= v;
        `CHK(pinOut[31:0], outM)
        v = rnd();
        wr(ad(0, `FGP_IDX_CLR), v, 4'hf);
        outM &= ~v;
        `CHK(pinOut[31:0], outM)
        mskM = rnd();
        wr(ad(0, `FGP_IDX_MASK), mskM, 4'hf);
        v = rnd();
        wr(ad(0, `FGP_IDX_OUT), v, 4'hf);
        wr(ad(0, `FGP_IDX_SET), 32'hffff_ffff, 4'hf);
        outM = outM & mskM | ~mskM;
        `CHK(pinOut[31:0], outM)
        rd(ad(0, `FGP_IDX_OUT), outM & ~mskM);
        wr(ad(0, `FGP_IDX_MASK), 32'h0, 4'hf);
        foreach (sl[i]) begin
            v = rnd();
            lateRdy = i[0];
            lm = {{8{sl[i][3]}}, {8{sl[i][2]}}, {8{sl[i][1]}}, {8{sl[i][0]}}};
            wr(ad(0, `FGP_IDX_OUT), v, sl[i]);
            outM = outM & ~lm | v & lm;
            `CHK(pinOut[31:0], outM)
        end
        lateRdy = 1'b0;
        // bit 7 set aliases onto the direction register if decode ignores it
        wr(8'h80, 32'hffff_ffff, 4'hf);
        `CHK(pinOe[31:0], dirM)
        wr(ad(1, `FGP_IDX_RISE), 32'h5, 4'hf);
        wr(ad(1, `FGP_IDX_FALL), 32'h6, 4'hf);
        wr(ad(1, `FGP_IDX_IMASK), 32'h7, 4'hf);
        extLvl[33] <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(irq, 1'b0)
        extLvl[32] <= 1'b1;
        @(posedge clk);
        `CHK(irq, 1'b0)
        `CHK(wake, 1'b1)
        repeat (5) @(posedge clk);
        `CHK(irq, 1'b1)
        `CHK(wake, 1'b0)
        wr(ad(1, `FGP_IDX_IMASK), 32'h6, 4'hf);
        `CHK(irq, 1'b0)
        rd(ad(1, `FGP_IDX_STAT), 32'h1);
        wr(ad(1, `FGP_IDX_STAT), 32'h1, 4'hf);
        rd(ad(1, `FGP_IDX_STAT), 32'h0);
        extLvl[33:32] <= 2'b00;
        repeat (6) @(posedge clk);
        rd(ad(1, `FGP_IDX_STAT), 32'h2);
        for (int i = 0; i < 2; i++) begin
            extLvl[34] <= ~extLvl[34];
            repeat (6) @(posedge clk);
            rd(ad(1, `FGP_IDX_STAT), 32'h6);
            wr(ad(1, `FGP_IDX_STAT), 32'h4, 4'hf);
        end
        `CHK(irq, 1'b1)
        wr(ad(1, `FGP_IDX_STAT), 32'hffff_ffff, 4'hf);
        `CHK(irq, 1'b0)
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK(pinOe | pinOut, 64'h0)
        rd(ad(0, `FGP_IDX_DIR), 32'h0);
        summarize();
    end
endmodule
bind fgp_gpio_top fgp_gpio_chk uChk (.*);
`default_nettype wire
